/* shared/clkgen_defs.svh */
// offsets, field positions, reset values and timing counts for the
// sample clock generator control block; included by bare name
`ifndef CLKGEN_DEFS_SVH
`define CLKGEN_DEFS_SVH

// register indices
`define GEN2_MODE_IDX 6'h13
`define GEN2_SAMPLE_RATE_IDX 6'h14
`define GEN2_PHASE_SHIFT_IDX 6'h15
`define GEN3_MODE_IDX 6'h16

// reset values
`define GEN2_MODE_RST 16'h00FF
`define GEN2_SAMPLE_RATE_RST 16'hBB80
`define GEN2_PHASE_SHIFT_RST 16'h0000
`define GEN3_MODE_RST 16'h00FF

// mode register fields
`define MODE_REF_BIT 15
`define MODE_VID_BIT 14
`define MODE_P200_BIT 12
`define MODE_X87_BIT 11
`define MODE_LOCK_TYPE_BIT 7
`define MODE_BASE_HI 6
`define MODE_BASE_LO 4
`define MODE_DIV_HI 3
`define MODE_DIV_LO 0

// phase shift register fields
`define PHASE_DIR_BIT 8
`define PHASE_MAG_HI 7
`define PHASE_MAG_LO 0
`define PHASE_USED_MASK 16'h01FF

// base rates in hertz
`define BASE_48000 16'hBB80
`define BASE_32000 16'h7D00
`define BASE_44100 16'hAC44
`define BASE_29400 16'h72D8
`define BASE_44056 16'hAC18

// phase decrement rate: 3.072 MHz, period in picoseconds
`define SYS_CLK_MHZ 200
`define PHASE_STEP_PS 325521
`define PHASE_STEP_CYCLES ((`PHASE_STEP_PS * `SYS_CLK_MHZ) / 1000000)

`endif

/* shared/clkgen_pkg.sv */
// types shared by the sample clock generator control block
package clkgen_pkg;
    typedef enum logic [1:0] {
        ECHO_IDLE,
        ECHO_ARMED,
        ECHO_SEND
    } echo_state_t;

    typedef logic [15:0] reg_word_t;
endpackage

/* shared/phase_if.sv */
// carrier between the control block and the phase shift counter
// assumes both ends share sys_clk
`timescale 1ns/1ps
interface phase_if #(parameter int MAG_W = 8);
    logic clear;
    logic load;
    logic load_dir;
    logic [MAG_W-1:0] load_mag;
    logic tick;
    logic pend_dir;
    logic [MAG_W-1:0] pend_mag;
    logic step;

    modport ctrl (
        output clear,
        output load,
        output load_dir,
        output load_mag,
        output tick,
        input pend_dir,
        input pend_mag,
        input step
    );

    modport cnt (
        input clear,
        input load,
        input load_dir,
        input load_mag,
        input tick,
        output pend_dir,
        output pend_mag,
        output step
    );
endinterface

/* src/phase_counter.sv */
// pending phase shift: loads, replaces and counts down one lsb per tick
// assumes tick is a one-cycle enable on sys_clk
`timescale 1ns/1ps
module phase_counter #(
    parameter int MAG_W = 8
) (
    input wire logic sys_clk,
    input wire logic rst,
    phase_if.cnt pif
);
    logic [MAG_W-1:0] mag_ff;
    logic dir_ff;
    logic step_ff;
    logic [MAG_W-1:0] nxt_mag;
    logic busy;

    generate
        if (MAG_W < 1) begin : g_chk
            $error("phase magnitude width must be at least one");
        end
    endgenerate

    assign busy = (mag_ff != '0);
    // a new write replaces whatever is still pending
    assign nxt_mag = pif.clear ? '0 :
                     pif.load ? pif.load_mag :
                     (pif.tick && busy) ? mag_ff - 1'b1 : mag_ff;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            mag_ff <= '0;
            dir_ff <= 1'b0;
            step_ff <= 1'b0;
        end else begin
            mag_ff <= nxt_mag;
            dir_ff <= pif.clear ? 1'b0 : (pif.load ? pif.load_dir : dir_ff);
            step_ff <= !pif.clear && !pif.load && pif.tick && busy;
        end
    end

    assign pif.pend_mag = mag_ff;
    assign pif.pend_dir = dir_ff;
    assign pif.step = step_ff;
endmodule

/* src/sample_clock_ctrl.sv */
// control registers of sample clock generator 2 and generator 3 mode
// assumes the serial port logic delivers register accesses and slot
// strobes on sys_clk; reset_pin_n, power_down_pin_n and frame_sync_in
// are raw pins
`timescale 1ns/1ps
`include "clkgen_defs.svh"
module sample_clock_ctrl #(
    parameter int STEP_CYCLES = `PHASE_STEP_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic reset_pin_n,
    input wire logic power_down_pin_n,
    input wire logic frame_sync_in,
    input wire logic gen2_enable,
    input wire logic bus_master,
    input wire logic slot0_start,
    input wire logic slot1_start,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [5:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    output logic reg_rvalid,
    output logic [15:0] echo_data,
    output logic echo_valid,
    output logic gen2_video_lock,
    output logic gen2_pal_lock,
    output logic gen2_sync_referenced,
    output logic gen2_bit_clock_on,
    output logic [15:0] gen2_base_rate_hz,
    output logic [3:0] gen2_divisor,
    output logic [15:0] gen2_rate_value,
    output logic gen2_eight_sevenths_on,
    output logic gen2_phase_step,
    output logic gen2_phase_direction,
    output logic gen3_master_ref,
    output logic gen3_eight_sevenths_on,
    output logic gen3_phase_from_reg,
    output logic gen3_bit_clock_offset
);
    // ************************************************************
    // elaboration check and helpers
    // ************************************************************
    generate
        if (STEP_CYCLES < 2 || STEP_CYCLES > 127) begin : g_chk
            $error("phase step divider out of range");
        end
    endgenerate

    function automatic logic [15:0] base_rate(input logic [2:0] code, input logic pal);
        logic [15:0] hz;
        hz = 16'h0000;
        case (code)
            3'h0: hz = `BASE_48000;
            3'h1: hz = `BASE_32000;
            3'h2: hz = `BASE_44100;
            3'h3: hz = `BASE_29400;
            3'h4: hz = pal ? 16'h0000 : `BASE_48000;
            3'h5: hz = pal ? 16'h0000 : `BASE_44056;
            default: hz = 16'h0000;
        endcase
        return hz;
    endfunction

    function automatic logic addr_hit(input logic [5:0] a, input logic [5:0] idx);
        return a == idx;
    endfunction

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    logic [2:0] pin_raw;
    logic [2:0] pin_s1_ff;
    logic [2:0] pin_s2_ff;
    logic [2:0] pin_s3_ff;
    logic [2:0] pin_ff;

    assign pin_raw = {frame_sync_in, power_down_pin_n, reset_pin_n};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_sync
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    pin_s1_ff[gi] <= 1'b0;
                    pin_s2_ff[gi] <= 1'b0;
                    pin_s3_ff[gi] <= 1'b0;
                    pin_ff[gi] <= 1'b0;
                end else begin
                    pin_s1_ff[gi] <= pin_raw[gi];
                    pin_s2_ff[gi] <= pin_s1_ff[gi];
                    pin_s3_ff[gi] <= pin_s2_ff[gi];
                    if (pin_s2_ff[gi] == pin_s3_ff[gi]) begin
                        pin_ff[gi] <= pin_s3_ff[gi];
                    end
                end
            end
        end
    endgenerate

    logic fsync_d_ff;
    wire fsync_edge = pin_ff[2] && !fsync_d_ff;
    wire hold_all = !pin_ff[0] || !pin_ff[1];
    wire hold_phase = hold_all || !gen2_enable;
    wire frame_start = bus_master ? slot0_start : fsync_edge;

    // ************************************************************
    // register decode
    // ************************************************************
    wire wr_mode2 = reg_wr && addr_hit(reg_addr, `GEN2_MODE_IDX) && !hold_all;
    wire wr_rate2 = reg_wr && addr_hit(reg_addr, `GEN2_SAMPLE_RATE_IDX) && !hold_all;
    wire wr_phase2 = reg_wr && addr_hit(reg_addr, `GEN2_PHASE_SHIFT_IDX) && !hold_phase;
    wire wr_mode3 = reg_wr && addr_hit(reg_addr, `GEN3_MODE_IDX) && !hold_all;
    wire wr_any = wr_mode2 || wr_rate2 || wr_phase2 || wr_mode3;

    logic [15:0] mode2_ff;
    logic [15:0] rate2_ff;
    logic [15:0] mode3_ff;
    logic [15:0] phase_snap_ff;

    phase_if #(.MAG_W(8)) pif ();

    wire [15:0] phase_live = {7'h00, pif.pend_dir, pif.pend_mag};
    wire [15:0] prev_word = wr_mode2 ? mode2_ff :
                            wr_rate2 ? rate2_ff :
                            wr_phase2 ? phase_live : mode3_ff;
    wire [15:0] rd_word = addr_hit(reg_addr, `GEN2_MODE_IDX) ? mode2_ff :
                          addr_hit(reg_addr, `GEN2_SAMPLE_RATE_IDX) ? rate2_ff :
                          addr_hit(reg_addr, `GEN2_PHASE_SHIFT_IDX) ? phase_snap_ff :
                          addr_hit(reg_addr, `GEN3_MODE_IDX) ? mode3_ff : 16'h0000;

    // ************************************************************
    // control registers
    // ************************************************************
    always_ff @(posedge sys_clk) begin
        if (rst || hold_all) begin
            mode2_ff <= `GEN2_MODE_RST;
            rate2_ff <= `GEN2_SAMPLE_RATE_RST;
            mode3_ff <= `GEN3_MODE_RST;
        end else begin
            if (wr_mode2) begin
                mode2_ff <= reg_wdata;
            end
            if (wr_rate2) begin
                rate2_ff <= reg_wdata;
            end
            if (wr_mode3) begin
                mode3_ff <= reg_wdata;
            end
        end
    end

    // remaining shift is captured at frame start for readback
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            phase_snap_ff <= `GEN2_PHASE_SHIFT_RST;
            fsync_d_ff <= 1'b0;
        end else begin
            fsync_d_ff <= pin_ff[2];
            if (hold_phase) begin
                phase_snap_ff <= `GEN2_PHASE_SHIFT_RST;
            end else if (frame_start) begin
                phase_snap_ff <= phase_live;
            end
        end
    end

    // ************************************************************
    // phase shift countdown
    // ************************************************************
    logic [6:0] div_cnt_ff;
    logic tick_ff;
    wire div_wrap = div_cnt_ff == 7'(STEP_CYCLES - 1);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            div_cnt_ff <= 7'h00;
            tick_ff <= 1'b0;
        end else begin
            div_cnt_ff <= div_wrap ? 7'h00 : div_cnt_ff + 7'h01;
            tick_ff <= div_wrap;
        end
    end

    assign pif.clear = hold_phase;
    assign pif.load = wr_phase2;
    assign pif.load_dir = reg_wdata[`PHASE_DIR_BIT];
    assign pif.load_mag = reg_wdata[`PHASE_MAG_HI:`PHASE_MAG_LO];
    assign pif.tick = tick_ff;

    phase_counter #(.MAG_W(8)) u_phase (
        .sys_clk(sys_clk),
        .rst(rst),
        .pif(pif.cnt)
    );

    // ************************************************************
    // read port and write echo
    // ************************************************************
    clkgen_pkg::echo_state_t echo_st_ff;
    clkgen_pkg::echo_state_t nxt_echo_st;
    clkgen_pkg::reg_word_t echo_hold_ff;
    logic [15:0] rdata_ff;
    logic rvalid_ff;
    logic [15:0] echo_data_ff;
    logic echo_valid_ff;

    // a write that one of the four registers accepts always restarts the echo; it goes out in the next frame
    always_comb begin
        nxt_echo_st = echo_st_ff;
        case (echo_st_ff)
            clkgen_pkg::ECHO_IDLE: nxt_echo_st = clkgen_pkg::ECHO_IDLE;
            clkgen_pkg::ECHO_ARMED: begin
                if (frame_start) begin
                    nxt_echo_st = clkgen_pkg::ECHO_SEND;
                end
            end
            clkgen_pkg::ECHO_SEND: begin
                if (slot1_start) begin
                    nxt_echo_st = clkgen_pkg::ECHO_IDLE;
                end
            end
            default: nxt_echo_st = clkgen_pkg::ECHO_IDLE;
        endcase
        if (wr_any) begin
            nxt_echo_st = clkgen_pkg::ECHO_ARMED;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            echo_st_ff <= clkgen_pkg::ECHO_IDLE;
            echo_hold_ff <= 16'h0000;
            echo_data_ff <= 16'h0000;
            echo_valid_ff <= 1'b0;
            rdata_ff <= 16'h0000;
            rvalid_ff <= 1'b0;
        end else begin
            echo_st_ff <= nxt_echo_st;
            if (wr_any) begin
                echo_hold_ff <= prev_word;
            end
            echo_valid_ff <= (echo_st_ff == clkgen_pkg::ECHO_SEND) && slot1_start && !wr_any;
            if ((echo_st_ff == clkgen_pkg::ECHO_SEND) && slot1_start) begin
                echo_data_ff <= echo_hold_ff;
            end
            rvalid_ff <= reg_rd;
            if (reg_rd) begin
                rdata_ff <= rd_word;
            end
        end
    end

    // ************************************************************
    // rate decode
    // ************************************************************
    wire vid2 = mode2_ff[`MODE_REF_BIT] && mode2_ff[`MODE_VID_BIT];
    wire pal2 = mode2_ff[`MODE_LOCK_TYPE_BIT];
    wire [2:0] base_code = mode2_ff[`MODE_BASE_HI:`MODE_BASE_LO];
    wire [3:0] div_code = mode2_ff[`MODE_DIV_HI:`MODE_DIV_LO];
    wire ref3 = mode3_ff[`MODE_REF_BIT];
    logic [8:0] dec_ff;

    // unlisted pairs pass through unchecked
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            dec_ff <= 9'h000;
            gen2_base_rate_hz <= 16'h0000;
            gen2_divisor <= 4'h0;
            gen2_rate_value <= `GEN2_SAMPLE_RATE_RST;
        end else begin
            dec_ff[0] <= vid2;
            dec_ff[1] <= vid2 && pal2;
            dec_ff[2] <= mode2_ff[`MODE_REF_BIT];
            dec_ff[3] <= !vid2;
            dec_ff[4] <= !mode2_ff[`MODE_REF_BIT] && mode2_ff[`MODE_X87_BIT];
            dec_ff[5] <= !ref3;
            dec_ff[6] <= !ref3 && mode3_ff[`MODE_X87_BIT];
            dec_ff[7] <= !ref3;
            dec_ff[8] <= mode3_ff[`MODE_P200_BIT] && !(ref3 && mode3_ff[`MODE_VID_BIT]);
            gen2_base_rate_hz <= vid2 ? base_rate(base_code, pal2) : 16'h0000;
            gen2_divisor <= vid2 ? div_code + 4'h1 : 4'h0;
            gen2_rate_value <= rate2_ff;
        end
    end

    assign gen2_video_lock = dec_ff[0];
    assign gen2_pal_lock = dec_ff[1];
    assign gen2_sync_referenced = dec_ff[2];
    assign gen2_bit_clock_on = dec_ff[3];
    assign gen2_eight_sevenths_on = dec_ff[4];
    assign gen3_master_ref = dec_ff[5];
    assign gen3_eight_sevenths_on = dec_ff[6];
    assign gen3_phase_from_reg = dec_ff[7];
    assign gen3_bit_clock_offset = dec_ff[8];
    assign gen2_phase_step = pif.step;
    assign gen2_phase_direction = pif.pend_dir;
    assign reg_rdata = rdata_ff;
    assign reg_rvalid = rvalid_ff;
    assign echo_data = echo_data_ff;
    assign echo_valid = echo_valid_ff;
endmodule

/* dv/sample_clock_ctrl_props.sv */
// checker for the sample clock control block
// assumes it is bound into sample_clock_ctrl and sees only its ports
`timescale 1ns/1ps
module sample_clock_ctrl_props #(
    parameter int STEP_CYCLES = 65
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic reset_pin_n,
    input wire logic power_down_pin_n,
    input wire logic gen2_enable,
    input wire logic slot1_start,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [5:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_rvalid,
    input wire logic echo_valid,
    input wire logic gen2_video_lock,
    input wire logic gen2_pal_lock,
    input wire logic gen2_bit_clock_on,
    input wire logic [3:0] gen2_divisor,
    input wire logic [15:0] gen2_rate_value,
    input wire logic gen2_phase_step
);
    // ****************************************
    // helper counters
    // ****************************************
    logic [3:0] ok_ff;
    logic [3:0] lo_ff;
    logic [7:0] gap_ff;
    wire logic pins_hi = reset_pin_n && power_down_pin_n;
    wire logic [3:0] nxt_ok = !pins_hi ? 4'h0 : (ok_ff == 4'hF) ? ok_ff : ok_ff + 4'h1;
    wire logic [3:0] nxt_lo = pins_hi ? 4'h0 : (lo_ff == 4'hF) ? lo_ff : lo_ff + 4'h1;
    wire logic [7:0] nxt_gap = gen2_phase_step ? 8'h00 : (gap_ff == 8'hFF) ? gap_ff : gap_ff + 8'h01;
    always_ff @(posedge sys_clk) begin
        ok_ff <= rst ? 4'h0 : nxt_ok;
        lo_ff <= rst ? 4'h0 : nxt_lo;
        gap_ff <= rst ? 8'hFF : nxt_gap;
    end

    // ****************************************
    // properties
    // ****************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    property p_no_bit_clock;
        gen2_video_lock |-> !gen2_bit_clock_on;
    endproperty
    a_no_bit_clock: assert property (p_no_bit_clock) else $error("bit clock in video lock");
    property p_pal_video;
        gen2_pal_lock |-> gen2_video_lock;
    endproperty
    a_pal_video: assert property (p_pal_video) else $error("pal lock outside video lock");
    property p_idle_div;
        !gen2_video_lock |-> gen2_divisor == 4'h0;
    endproperty
    a_idle_div: assert property (p_idle_div) else $error("divisor outside video lock");
    property p_div_write;
        logic [3:0] d;
        (reg_wr && reg_addr == 6'h13 && reg_wdata[15:14] == 2'b11 && ok_ff == 4'hF,
            d = reg_wdata[3:0] + 4'h1) |-> ##2 gen2_divisor == d;
    endproperty
    a_div_write: assert property (p_div_write) else $error("divisor not code plus one");
    property p_rate_write;
        logic [15:0] v;
        (reg_wr && reg_addr == 6'h14 && ok_ff == 4'hF, v = reg_wdata) |-> ##2 gen2_rate_value == v;
    endproperty
    a_rate_write: assert property (p_rate_write) else $error("rate write lost");
    property p_rate_hold;
        lo_ff >= 4'h8 |-> gen2_rate_value == 16'hBB80;
    endproperty
    a_rate_hold: assert property (p_rate_hold) else $error("rate not held at default");
    property p_echo_slot;
        echo_valid |-> $past(slot1_start);
    endproperty
    a_echo_slot: assert property (p_echo_slot) else $error("echo outside slot 1");
    property p_step_gap;
        gen2_phase_step |-> gap_ff >= STEP_CYCLES - 1;
    endproperty
    a_step_gap: assert property (p_step_gap) else $error("phase steps too close");
    property p_phase_off;
        !gen2_enable [*4] |-> !gen2_phase_step;
    endproperty
    a_phase_off: assert property (p_phase_off) else $error("phase step while disabled");
    property p_read_ans;
        reg_rd |=> reg_rvalid;
    endproperty
    a_read_ans: assert property (p_read_ans) else $error("read not answered");

    c_pal: cover property (gen2_pal_lock);
    c_echo: cover property (echo_valid);
    c_step: cover property (gen2_phase_step);
endmodule

bind sample_clock_ctrl sample_clock_ctrl_props #(.STEP_CYCLES(STEP_CYCLES)) u_props (
    .sys_clk, .rst, .reset_pin_n, .power_down_pin_n, .gen2_enable, .slot1_start,
    .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rvalid, .echo_valid,
    .gen2_video_lock, .gen2_pal_lock, .gen2_bit_clock_on, .gen2_divisor,
    .gen2_rate_value, .gen2_phase_step
);

/* dv/frame_host.sv */
// serial frame timing of the host side: one frame per go pulse
// assumes go is driven away from the rising edge of sys_clk
`timescale 1ns/1ps
module frame_host (
    input wire logic sys_clk,
    input wire logic go,
    output logic slot0_start,
    output logic slot1_start,
    output logic frame_sync_in
);
    logic [3:0] pos_ff = 4'h0;
    wire logic [3:0] nxt_pos = (pos_ff != 4'h0 || go) ? pos_ff + 4'h1 : 4'h0;
    always @(posedge sys_clk) begin
        pos_ff <= nxt_pos;
    end
    // frame sync is low between frames, slot 1 comes after the synced sync edge
    assign slot0_start = (pos_ff == 4'h1);
    assign slot1_start = (pos_ff == 4'h9);
    assign frame_sync_in = (pos_ff != 4'h0) && (pos_ff < 4'h5);
endmodule

/* dv/sample_clock_ctrl_tb.sv */
// self-checking bench for the sample clock control block
// assumes the bound checker and frame_host beside it
`timescale 1ns/1ps
`include "clkgen_defs.svh"
module sample_clock_ctrl_tb;
    localparam int STEP = 4;
    logic sys_clk, rst, reset_pin_n, power_down_pin_n, gen2_enable, bus_master, go;
    logic reg_wr, reg_rd, reg_rvalid, echo_valid, got_echo, pal;
    logic gen2_video_lock, gen2_pal_lock, gen2_sync_referenced, gen2_bit_clock_on;
    logic gen2_eight_sevenths_on, gen2_phase_step, gen2_phase_direction;
    logic gen3_master_ref, gen3_eight_sevenths_on, gen3_phase_from_reg, gen3_bit_clock_offset;
    logic [5:0] reg_addr;
    logic [3:0] gen2_divisor, b;
    logic [15:0] reg_wdata, reg_rdata, echo_data, gen2_base_rate_hz, gen2_rate_value;
    logic [15:0] echo_cap, r1, r2, m, prev;
    wire logic slot0_start, slot1_start, frame_sync_in;
    int n_errors = 0;
    int checked = 0;
    int cycles = 0;
    int k;
    logic [5:0] ra [5] = '{6'h13, 6'h14, 6'h15, 6'h16, 6'h20};
    logic [15:0] rv [5] = '{16'h00FF, 16'hBB80, 16'h0000, 16'h00FF, 16'h0000};
    logic [15:0] bs [6] = '{`BASE_48000, `BASE_32000, `BASE_44100, `BASE_29400,
        `BASE_48000, `BASE_44056};
    logic [3:0] dv [10] = '{4'h7, 4'h4, 4'h2, 4'h1, 4'h5, 4'h6, 4'h6, 4'h3, 4'h7, 4'h0};

    sample_clock_ctrl #(.STEP_CYCLES(STEP)) uut (
        .sys_clk, .rst, .reset_pin_n, .power_down_pin_n, .frame_sync_in, .gen2_enable,
        .bus_master, .slot0_start, .slot1_start, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
        .reg_rdata, .reg_rvalid, .echo_data, .echo_valid, .gen2_video_lock, .gen2_pal_lock,
        .gen2_sync_referenced, .gen2_bit_clock_on, .gen2_base_rate_hz, .gen2_divisor,
        .gen2_rate_value, .gen2_eight_sevenths_on, .gen2_phase_step, .gen2_phase_direction,
        .gen3_master_ref, .gen3_eight_sevenths_on, .gen3_phase_from_reg, .gen3_bit_clock_offset
    );
    frame_host host (.sys_clk, .go, .slot0_start, .slot1_start, .frame_sync_in);

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            results();
        end
    end

    // ****************************************
    // access tasks
    // ****************************************
    task check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task wr(input logic [5:0] a, input logic [15:0] d);
        @(negedge sys_clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge sys_clk);
        reg_wr = 1'b0;
    endtask
    task rd(input logic [5:0] a, output logic [15:0] d);
        @(negedge sys_clk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge sys_clk);
        reg_rd = 1'b0;
        check(reg_rvalid, 16'h0001, "read valid");
        d = reg_rdata;
    endtask
    task frame;
        @(negedge sys_clk);
        go = 1'b1;
        @(negedge sys_clk);
        go = 1'b0;
        got_echo = 1'b0;
        repeat (16) begin
            @(negedge sys_clk);
            if (echo_valid === 1'b1) begin
                got_echo = 1'b1;
                echo_cap = echo_data;
            end
        end
    endtask
    task steps(input int n);
        k = 0;
        repeat (n) begin
            @(negedge sys_clk);
            if (gen2_phase_step === 1'b1) k++;
        end
    endtask
    task results;
        $display("mismatches %0d comparisons %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // ****************************************
    // tests
    // ****************************************
    initial begin
        rst = 1'b1;
        {reset_pin_n, power_down_pin_n, gen2_enable, bus_master} = 4'hF;
        {go, reg_wr, reg_rd} = 3'h0;
        reg_addr = 6'h00;
        reg_wdata = 16'h0000;
        cyc(6);
        rst = 1'b0;
        cyc(8);
        for (int i = 0; i < 5; i++) begin
            rd(ra[i], r1);
            check(r1, rv[i], "reset value");
        end
        // reserved bits zero and permitted base and divisor pairs only
        for (int i = 0; i < 10; i++) begin
            pal = (i > 5);
            b = pal ? 4'(i - 6) : 4'(i);
            m = {2'b11, 6'h00, pal, b[2:0], dv[i]};
            wr(6'h13, m);
            cyc(2);
            check(gen2_video_lock, 16'h0001, "video lock");
            check(gen2_pal_lock, {15'h0000, pal}, "pal lock");
            check(gen2_bit_clock_on, 16'h0000, "bit clock");
            check(gen2_base_rate_hz, bs[b], "base rate");
            check(gen2_divisor, dv[i] + 4'h1, "divisor");
            if (i == 8) prev = m;
        end
        frame();
        check(echo_cap, prev, "mode echo");
        wr(6'h13, 16'h8800);
        cyc(2);
        check({gen2_video_lock, gen2_divisor, gen2_bit_clock_on, gen2_sync_referenced,
            gen2_eight_sevenths_on}, 16'h0006, "ref only");
        wr(6'h13, 16'h0800);
        cyc(2);
        check({gen2_sync_referenced, gen2_eight_sevenths_on, gen2_bit_clock_on}, 16'h0003,
            "master ref");
        wr(6'h16, 16'h0800);
        cyc(2);
        check({gen3_master_ref, gen3_eight_sevenths_on, gen3_phase_from_reg,
            gen3_bit_clock_offset}, 16'h000E, "gen3 master");
        wr(6'h16, 16'h1000);
        cyc(2);
        check({gen3_master_ref, gen3_eight_sevenths_on, gen3_phase_from_reg,
            gen3_bit_clock_offset}, 16'h000B, "gen3 offset");
        wr(6'h14, 16'h0FA0);
        cyc(2);
        check(gen2_rate_value, 16'h0FA0, "rate low");
        wr(6'h14, 16'hD2F0);
        rd(6'h14, r1);
        check(r1, 16'hD2F0, "rate high");
        frame();
        check({got_echo, echo_cap[14:0]}, 16'h8FA0, "rate echo");
        for (int j = 0; j < 2; j++) begin
            wr(6'h14, 16'h1F40);
            {reset_pin_n, power_down_pin_n} = j ? 2'b10 : 2'b01;
            cyc(8);
            check(gen2_rate_value, 16'hBB80, "rate held");
            wr(6'h13, 16'hC000);
            cyc(4);
            {reset_pin_n, power_down_pin_n} = 2'b11;
            cyc(8);
            rd(6'h13, r1);
            check(r1, 16'h00FF, "mode held");
            rd(6'h14, r1);
            check(r1, 16'hBB80, "rate after hold");
        end
        wr(6'h15, 16'h0105);
        steps(40);
        check(gen2_phase_direction, 16'h0001, "retard");
        check(16'(k), 16'h0005, "step count");
        wr(6'h15, 16'h0050);
        cyc(20);
        wr(6'h15, 16'h0002);
        steps(40);
        check(gen2_phase_direction, 16'h0000, "advance");
        check(16'(k), 16'h0002, "replaced count");
        wr(6'h15, 16'h01C8);
        frame();
        check(echo_cap, 16'h0000, "phase echo");
        rd(6'h15, r1);
        cyc(20);
        rd(6'h15, r2);
        check(r2, r1, "snapshot");
        check({r1[8], r1[7:0] > 8'hB0, r1[7:0] <= 8'hC8}, 16'h0007, "remaining");
        cyc(850);
        bus_master = 1'b0;
        frame();
        rd(6'h15, r1);
        check(r1[7:0], 16'h0000, "drained");
        bus_master = 1'b1;
        wr(6'h15, 16'h0040);
        cyc(10);
        gen2_enable = 1'b0;
        wr(6'h15, 16'h0005);
        cyc(4);
        gen2_enable = 1'b1;
        steps(40);
        check(16'(k), 16'h0000, "disabled steps");
        frame();
        rd(6'h15, r1);
        check(r1, 16'h0000, "disabled clear");
        results();
    end
endmodule
